// ==== src/pit_pkg.sv ====
// Constants shared by the periodic timer design files
package pit_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int PIT_CLK_HZ = 40_000_000;
	localparam int PIT_LOCK_STEP_MS = 10;
	localparam int PIT_LOCK_STEP_CYC = PIT_LOCK_STEP_MS * (PIT_CLK_HZ / 1000);
	localparam int PIT_LOCK_MAX_STEPS = 4;
	localparam int PIT_PRESCALE_DIV = 512;
	localparam int PIT_SYS_TICK_DIV = 1220;

	// ****************************************
	// Register map (byte offsets)
	// ****************************************
	localparam logic [3:0] PIT_OFF_CTRL = 4'h0;
	localparam logic [3:0] PIT_OFF_CFG = 4'h4;
	localparam logic [3:0] PIT_OFF_STAT = 4'h8;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int PIT_CTRL_PM_LSB = 0;
	localparam int PIT_CTRL_PRE_BIT = 8;
	localparam int PIT_CFG_LVL_LSB = 0;
	localparam int PIT_CFG_SEL_BIT = 4;
	localparam int PIT_STAT_IRQ_BIT = 0;
	localparam int PIT_STAT_RUN_BIT = 1;
	localparam int PIT_STAT_LOCK_BIT = 2;
	localparam int PIT_STAT_HOLD_BIT = 3;
	localparam int PIT_STAT_CNT_LSB = 8;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] PIT_PM_RST = 8'h00;
	localparam logic PIT_PRE_RST = 1'b0;
	localparam logic [2:0] PIT_LVL_RST = 3'h0;
	localparam logic PIT_SEL_RST = 1'b0;

	typedef enum logic [1:0] {
		PIT_LK_RELOCK = 2'b01,
		PIT_LK_LOCKED = 2'b10
	} pit_lock_type;

endpackage

// ==== src/pit_sync.sv ====
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
module pit_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;

	// The first stage feeds only the second stage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_ff <= '0;
			sync_out <= '0;
		end else begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule

// ==== src/pit_timer.sv ====
// Periodic timer with AHB-Lite registers, clock source selection and lock-status logic
`timescale 1ns/10ps
// Behaviour
// - writing zero period stops; nonzero restarts
// - running rewrite finishes old period first
// - in stop with select 0, reference drives counter
// - outside stop, reference tick is resynchronised
// - bus held after stop until lock flag
// - lock flag deasserted during relock, 10 ms steps
// - prescale enable divides reference by 512
module pit_timer
	import pit_pkg::*;
#(
	parameter int LOCK_STEP_CYC = pit_pkg::PIT_LOCK_STEP_CYC,
	parameter int PRESCALE_DIV = pit_pkg::PIT_PRESCALE_DIV,
	parameter int SYS_TICK_DIV = pit_pkg::PIT_SYS_TICK_DIV
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Pins and system signals
	input wire logic reference_clock_input,
	input wire logic synth_lock_raw,
	input wire logic low_power_stop,
	// Timer and lock outputs
	output logic [2:0] timer_irq_level,
	output logic synth_lock_flag,
	output logic bus_hold
);
	import pit_pkg::*;

	localparam int LCW = $clog2(LOCK_STEP_CYC);
	localparam int DVW = $clog2(PRESCALE_DIV);
	localparam int SDW = $clog2(SYS_TICK_DIV);

	generate
		if (LOCK_STEP_CYC < 2 || PRESCALE_DIV < 2 || SYS_TICK_DIV < 2) begin : g_bad_param
			$error("pit_timer: divider and step counts must be at least 2");
		end
	endgenerate

	typedef struct packed {
		logic dp_valid;
		logic dp_write;
		logic [3:0] dp_addr;
		logic [31:0] rdata;
		logic [7:0] period;
		logic [7:0] count;
		logic running;
		logic pre_en;
		logic stop_sel;
		logic [2:0] level;
		logic irq_pend;
		logic [2:0] irq_out;
		logic ref_q;
		logic [DVW-1:0] div;
		logic [SDW-1:0] sdiv;
		logic tick_q;
		logic lps_q;
		pit_lock_type lk;
		logic [LCW-1:0] lock_cnt;
		logic [2:0] steps;
		logic held_ok;
		logic flag;
		logic hold;
	} pit_state_type;

	pit_state_type r_ff;
	pit_state_type nxt_r;
	logic [1:0] sync_v;
	logic ref_s;
	logic lock_s;

	// ****************************************
	// Input synchronisers
	// ****************************************
	pit_sync #(
		.WIDTH(2)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in({synth_lock_raw, reference_clock_input}),
		.sync_out(sync_v)
	);
	assign ref_s = sync_v[0];
	assign lock_s = sync_v[1];

	function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] off);
		reg_hit = (a == off);
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	logic ref_edge;
	logic div_wrap;
	logic pre_tick;
	logic sys_tick;
	logic cnt_tick;
	logic wr_commit;
	logic wr_ctrl;
	logic [7:0] wr_pm;
	logic was_running;
	logic stop_exit;
	logic relock_start;
	logic step_end;

	always_comb begin
		nxt_r = r_ff;
		ref_edge = ref_s && !r_ff.ref_q;
		div_wrap = (r_ff.div == DVW'(PRESCALE_DIV - 1));
		pre_tick = r_ff.pre_en ? (ref_edge && div_wrap) : ref_edge;
		sys_tick = (r_ff.sdiv == SDW'(SYS_TICK_DIV - 1));
		wr_commit = r_ff.dp_valid && r_ff.dp_write;
		wr_ctrl = wr_commit && reg_hit(r_ff.dp_addr, PIT_OFF_CTRL);
		wr_pm = hwdata[PIT_CTRL_PM_LSB +: 8];
		was_running = r_ff.running;
		stop_exit = r_ff.lps_q && !low_power_stop;
		relock_start = stop_exit || (r_ff.lk == PIT_LK_LOCKED && !lock_s);
		step_end = (r_ff.lock_cnt == LCW'(LOCK_STEP_CYC - 1));

		// Reference edge detect and prescaler
		nxt_r.ref_q = ref_s;
		if (ref_edge && r_ff.pre_en) begin
			nxt_r.div = div_wrap ? '0 : r_ff.div + DVW'(1);
		end
		nxt_r.sdiv = sys_tick ? '0 : r_ff.sdiv + SDW'(1);
		nxt_r.lps_q = low_power_stop;

		// Outside stop the tick takes one more system-clock stage; in stop with select 0 the
		// reference tick reaches the counter directly, select 1 counts the system divider.
		nxt_r.tick_q = !low_power_stop && pre_tick;
		if (!low_power_stop) begin
			cnt_tick = r_ff.tick_q;
		end else if (!r_ff.stop_sel) begin
			cnt_tick = pre_tick;
		end else begin
			cnt_tick = sys_tick;
		end

		// Register writes (data phase)
		if (wr_ctrl) begin
			nxt_r.pre_en = hwdata[PIT_CTRL_PRE_BIT];
			if (wr_pm == 8'h00) begin
				nxt_r.running = 1'b0;
				nxt_r.period = 8'h00;
				nxt_r.count = 8'h00;
			end else if (!r_ff.running) begin
				nxt_r.running = 1'b1;
				nxt_r.period = wr_pm;
				nxt_r.count = wr_pm;
			end else begin
				nxt_r.period = wr_pm;
			end
		end
		if (wr_commit && reg_hit(r_ff.dp_addr, PIT_OFF_CFG)) begin
			nxt_r.level = hwdata[PIT_CFG_LVL_LSB +: 3];
			nxt_r.stop_sel = hwdata[PIT_CFG_SEL_BIT];
		end
		if (wr_commit && reg_hit(r_ff.dp_addr, PIT_OFF_STAT) && hwdata[PIT_STAT_IRQ_BIT]) begin
			nxt_r.irq_pend = 1'b0;
		end

		// Counting; the reload uses the latest period so a running rewrite lands at terminal count
		if (was_running && nxt_r.running && cnt_tick) begin
			if (r_ff.count == 8'h01) begin
				nxt_r.count = nxt_r.period;
				nxt_r.irq_pend = 1'b1;
			end else begin
				nxt_r.count = r_ff.count - 8'h01;
			end
		end
		nxt_r.irq_out = nxt_r.irq_pend ? nxt_r.level : 3'h0;

		// Lock detect: flag clears at once on relock and rises only at step boundaries, forced at the last step if locked
		if (relock_start) begin
			nxt_r.lk = PIT_LK_RELOCK;
			nxt_r.lock_cnt = '0;
			nxt_r.steps = 3'h0;
			nxt_r.held_ok = 1'b1;
			nxt_r.flag = 1'b0;
		end else begin
			unique case (r_ff.lk)
				PIT_LK_RELOCK: begin
					nxt_r.flag = 1'b0;
					nxt_r.held_ok = r_ff.held_ok && lock_s;
					nxt_r.lock_cnt = step_end ? '0 : r_ff.lock_cnt + LCW'(1);
					if (step_end) begin
						nxt_r.steps = r_ff.steps + 3'h1;
						nxt_r.held_ok = 1'b1;
						if (lock_s && (r_ff.held_ok || r_ff.steps == 3'(PIT_LOCK_MAX_STEPS - 1))) begin
							nxt_r.lk = PIT_LK_LOCKED;
							nxt_r.flag = 1'b1;
						end
					end
				end
				PIT_LK_LOCKED: begin
					nxt_r.flag = 1'b1;
				end
			endcase
		end

		// Processor stays off the bus from stop exit until lock is reported
		nxt_r.hold = stop_exit || (r_ff.hold && !nxt_r.flag);

		// Bus address phase; read data built from post-write values
		nxt_r.dp_valid = hsel && hready && htrans[1];
		nxt_r.dp_write = hwrite;
		nxt_r.dp_addr = haddr[3:0];
		nxt_r.rdata = 32'h0000_0000;
		if (hsel && hready && htrans[1] && !hwrite) begin
			if (reg_hit(haddr[3:0], PIT_OFF_CTRL)) begin
				nxt_r.rdata[PIT_CTRL_PM_LSB +: 8] = nxt_r.period;
				nxt_r.rdata[PIT_CTRL_PRE_BIT] = nxt_r.pre_en;
			end else if (reg_hit(haddr[3:0], PIT_OFF_CFG)) begin
				nxt_r.rdata[PIT_CFG_LVL_LSB +: 3] = nxt_r.level;
				nxt_r.rdata[PIT_CFG_SEL_BIT] = nxt_r.stop_sel;
			end else if (reg_hit(haddr[3:0], PIT_OFF_STAT)) begin
				nxt_r.rdata[PIT_STAT_IRQ_BIT] = nxt_r.irq_pend;
				nxt_r.rdata[PIT_STAT_RUN_BIT] = nxt_r.running;
				nxt_r.rdata[PIT_STAT_LOCK_BIT] = nxt_r.flag;
				nxt_r.rdata[PIT_STAT_HOLD_BIT] = nxt_r.hold;
				nxt_r.rdata[PIT_STAT_CNT_LSB +: 8] = nxt_r.count;
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_ff <= '{dp_valid: 1'b0, dp_write: 1'b0, dp_addr: 4'h0, rdata: 32'h0000_0000,
				period: PIT_PM_RST, count: 8'h00, running: 1'b0, pre_en: PIT_PRE_RST,
				stop_sel: PIT_SEL_RST, level: PIT_LVL_RST, irq_pend: 1'b0, irq_out: 3'h0,
				ref_q: 1'b0, div: '0, sdiv: '0, tick_q: 1'b0, lps_q: 1'b0, lk: PIT_LK_RELOCK,
				lock_cnt: '0, steps: 3'h0, held_ok: 1'b1, flag: 1'b0, hold: 1'b0};
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign hrdata = r_ff.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign timer_irq_level = r_ff.irq_out;
	assign synth_lock_flag = r_ff.flag;
	assign bus_hold = r_ff.hold;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic quiet_wr;
	assign quiet_wr = !(r_ff.dp_valid && r_ff.dp_write);

	property p_stop_on_zero;
		wr_ctrl && wr_pm == 8'h00 |=> !r_ff.running && r_ff.count == 8'h00 && timer_irq_level == $past(r_ff.irq_out);
	endproperty
	a_stop_on_zero: assert property (p_stop_on_zero) else $error("zero period did not stop");

	property p_restart;
		wr_ctrl && wr_pm != 8'h00 && !r_ff.running |=> r_ff.running && r_ff.count == $past(wr_pm);
	endproperty
	a_restart: assert property (p_restart) else $error("nonzero period did not restart");

	property p_rewrite_keeps_count;
		wr_ctrl && wr_pm != 8'h00 && r_ff.running && r_ff.count > 8'h01
			|=> r_ff.period == $past(wr_pm) && (r_ff.count == $past(r_ff.count) || r_ff.count == $past(r_ff.count) - 8'h01);
	endproperty
	a_rewrite_keeps_count: assert property (p_rewrite_keeps_count) else $error("running rewrite disturbed count");

	property p_direct_in_stop;
		low_power_stop && !r_ff.stop_sel && !r_ff.pre_en && r_ff.running && ref_edge && r_ff.count > 8'h01 && quiet_wr
			|=> r_ff.count == $past(r_ff.count) - 8'h01;
	endproperty
	a_direct_in_stop: assert property (p_direct_in_stop) else $error("stop tick not taken directly");

	property p_resync_normal;
		!low_power_stop && !r_ff.pre_en && ref_edge |=> r_ff.tick_q ##1 !r_ff.tick_q;
	endproperty
	a_resync_normal: assert property (p_resync_normal) else $error("normal tick not retimed");

	property p_prescale;
		r_ff.tick_q && $past(r_ff.pre_en) |-> $past(div_wrap) && r_ff.div == '0;
	endproperty
	a_prescale: assert property (p_prescale) else $error("prescaled tick off the divider wrap");

	property p_hold_on_exit;
		$fell(low_power_stop) |=> bus_hold && !synth_lock_flag;
	endproperty
	a_hold_on_exit: assert property (p_hold_on_exit) else $error("bus not held after stop");

	property p_hold_release;
		$fell(bus_hold) |-> synth_lock_flag;
	endproperty
	a_hold_release: assert property (p_hold_release) else $error("bus released before lock");

	property p_lock_on_step;
		$rose(synth_lock_flag) |-> r_ff.lock_cnt == LCW'(LOCK_STEP_CYC - 1) || $past(step_end);
	endproperty
	a_lock_on_step: assert property (p_lock_on_step) else $error("lock flag off a step boundary");

	property p_terminal;
		r_ff.running && cnt_tick && r_ff.count == 8'h01 && quiet_wr
			|=> r_ff.irq_pend && r_ff.count == $past(r_ff.period) && timer_irq_level == r_ff.level;
	endproperty
	a_terminal: assert property (p_terminal) else $error("terminal count did not reload");

	c_irq: cover property (r_ff.running ##1 r_ff.irq_pend);
	c_rewrite: cover property (wr_ctrl && r_ff.running && wr_pm != r_ff.period);
	c_hold_release: cover property ($fell(bus_hold));
	c_stop_count: cover property (low_power_stop && cnt_tick && r_ff.running);
endmodule

// ==== testbench/pit_timer_tb_top.sv ====
// Self-checking testbench for the periodic timer
`timescale 1ns/10ps
module pit_timer_tb_top;
	import pit_pkg::*;

	// ****************************************
	// Signals
	// ****************************************
	localparam logic [31:0] A_CTRL = {28'h0, PIT_OFF_CTRL};
	localparam logic [31:0] A_CFG = {28'h0, PIT_OFF_CFG};
	localparam logic [31:0] A_STAT = {28'h0, PIT_OFF_STAT};
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize, timer_irq_level;
	logic reference_clock_input, synth_lock_raw, low_power_stop, synth_lock_flag, bus_hold;
	int num_errors = 0;
	int checks = 0;
	int cycles = 0;

	assign hready = hreadyout;

	// Small counts keep the lock steps and dividers short
	pit_timer #(.LOCK_STEP_CYC(16), .PRESCALE_DIV(4), .SYS_TICK_DIV(4)) uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .reference_clock_input(reference_clock_input),
		.synth_lock_raw(synth_lock_raw), .low_power_stop(low_power_stop),
		.timer_irq_level(timer_irq_level), .synth_lock_flag(synth_lock_flag), .bus_hold(bus_hold));

	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			end_sim();
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_out(input logic [2:0] got, input logic [2:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wait_rdy();
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
	endtask

	// Entered just after a rising edge; read data is taken at the end of the data phase
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
		chk_out({2'h0, hresp}, 3'h0);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk_word(q & mask, exp);
	endtask

	// Each pulse is long enough to survive the synchroniser, then the tick is let land
	// Eight system clocks per reference period keep the retiming margin
	task automatic pulses(input int n);
		repeat (n) begin
			reference_clock_input <= 1'b1;
			repeat (4) @(posedge hclk);
			reference_clock_input <= 1'b0;
			repeat (4) @(posedge hclk);
		end
		repeat (4) @(posedge hclk);
	endtask

	task automatic clr_irq();
		wr(A_STAT, 32'h1);
		repeat (2) @(posedge hclk);
		chk_out(timer_irq_level, 3'h0);
	endtask

	task automatic wait_lock();
		int n;
		n = 0;
		while (synth_lock_flag !== 1'b1 && n < 300) begin
			@(posedge hclk);
			n++;
		end
		chk_out({2'h0, synth_lock_flag}, 3'h1);
		chk_out({2'h0, bus_hold}, 3'h0);
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		reference_clock_input = 1'b0;
		synth_lock_raw = 1'b1;
		low_power_stop = 1'b0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		chk_out({2'h0, synth_lock_flag}, 3'h0);
		rd_chk(A_CTRL, 32'hFFFF_FFFF, 32'h0);
		rd_chk(A_CFG, 32'hFFFF_FFFF, 32'h0);
		rd_chk(32'h0000_000C, 32'hFFFF_FFFF, 32'h0);
		wait_lock();
		rd_chk(A_STAT, 32'hFFFF_FFFF, 32'h4);
		$display("test reset and lock done");

		// Raw lock drops while locked: flag falls, then returns at a clean step boundary
		synth_lock_raw <= 1'b0;
		repeat (4) @(posedge hclk);
		chk_out({2'h0, synth_lock_flag}, 3'h0);
		repeat (20) @(posedge hclk);
		chk_out({2'h0, synth_lock_flag}, 3'h0);
		synth_lock_raw <= 1'b1;
		wait_lock();
		$display("test lock loss done");

		wr(A_CFG, 32'h5);
		rd_chk(A_CFG, 32'hFFFF_FFFF, 32'h5);
		wr(A_CTRL, 32'h3);
		pulses(2);
		chk_out(timer_irq_level, 3'h0);
		pulses(1);
		chk_out(timer_irq_level, 3'h5);
		rd_chk(A_STAT, 32'hFFFF_FFFF, 32'h0307);
		clr_irq();
		$display("test expiry done");

		// Rewrite on the fly: old period runs out before the new one applies
		pulses(1);
		wr(A_CTRL, 32'h5);
		pulses(1);
		chk_out(timer_irq_level, 3'h0);
		pulses(1);
		chk_out(timer_irq_level, 3'h5);
		clr_irq();
		pulses(4);
		chk_out(timer_irq_level, 3'h0);
		pulses(1);
		chk_out(timer_irq_level, 3'h5);
		clr_irq();
		$display("test reload on the fly done");

		wr(A_CTRL, 32'h0);
		pulses(8);
		chk_out(timer_irq_level, 3'h0);
		rd_chk(A_STAT, 32'h3, 32'h0);
		wr(A_CTRL, 32'h2);
		pulses(1);
		chk_out(timer_irq_level, 3'h0);
		pulses(1);
		chk_out(timer_irq_level, 3'h5);
		clr_irq();
		$display("test stop and restart done");

		// Prescaler divider is still at its reset value of zero, so each group of four edges gives one tick
		wr(A_CTRL, 32'h0);
		wr(A_CTRL, 32'h102);
		pulses(4);
		chk_out(timer_irq_level, 3'h0);
		pulses(4);
		chk_out(timer_irq_level, 3'h5);
		clr_irq();
		$display("test prescaler done");

		wr(A_CTRL, 32'h0);
		wr(A_CTRL, 32'h2);
		repeat (8) @(posedge hclk);
		low_power_stop <= 1'b1;
		pulses(1);
		chk_out(timer_irq_level, 3'h0);
		pulses(1);
		chk_out(timer_irq_level, 3'h5);
		clr_irq();
		low_power_stop <= 1'b0;
		repeat (3) @(posedge hclk);
		chk_out({2'h0, bus_hold}, 3'h1);
		chk_out({2'h0, synth_lock_flag}, 3'h0);
		rd_chk(A_STAT, 32'hC, 32'h8);
		wait_lock();
		$display("test stop with reference clock done");

		// Select 1 in stop: counter runs from the divided system clock, reference idle
		wr(A_CTRL, 32'h0);
		wr(A_CFG, 32'h15);
		wr(A_CTRL, 32'h2);
		repeat (8) @(posedge hclk);
		low_power_stop <= 1'b1;
		repeat (30) @(posedge hclk);
		chk_out(timer_irq_level, 3'h5);
		clr_irq();
		low_power_stop <= 1'b0;
		repeat (3) @(posedge hclk);
		wait_lock();
		$display("test stop with system clock done");
		end_sim();
	end
endmodule
